// file: bpe_top.sv
`timescale 1ns/1ps
// What this block does
// - Event 61H adds one each time this processor raises bus_not_ready.
// - This agent raises bus_not_ready when its pending transactions near the bus limit.
// - No new bus transaction is issued while bus_not_ready is seen on the bus.
// - Events 61H to 64H count per physical bus, with no per-thread split.
// - Event 62H adds one on every bus cycle with data_valid_strobe asserted.
// - This agent asserts data_valid_strobe in every cycle it drives data.
// - Event 62H includes cycles of this processor's writebacks and partial writes.
// - Event 63H adds one on every bus cycle with the lock signal asserted.
// - The lock signal is raised for uncacheable, line-splitting or page-walk locks.
// - Event 64H adds one on every bus cycle this processor is receiving data.
// - Event 65H counts burst reads from data misses, prefetches and cacheable fetch misses.
// - Event 65H never counts read_for_ownership transactions.
// - Event 66H counts read_for_ownership issued for stores missing both caches.
// - Event 66H also counts read_for_ownership issued for locked operations.
module bpe_top
    import bpe_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] event_select_in,
    input wire logic count_enable_in,
    input wire logic count_clear_in,
    input wire logic [PEND_W-1:0] pending_count_in,
    input wire logic bus_not_ready_in,
    input wire logic data_drive_in,
    input wire logic data_valid_strobe_in,
    input wire logic receive_for_us_in,
    input wire logic lock_uncacheable_in,
    input wire logic lock_split_line_in,
    input wire logic lock_page_walk_in,
    input wire logic bus_lock_in,
    input wire logic req_valid_in,
    input wire logic [KIND_W-1:0] req_kind_in,
    input wire logic req_cacheable_in,
    output logic bus_not_ready_out,
    output logic data_valid_strobe_out,
    output logic bus_lock_out,
    output logic bus_req_out,
    output logic req_taken_out,
    output logic [CNT_W-1:0] count_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    bpe_link_if link ();

    logic not_ready_q;
    logic not_ready_d;
    logic not_ready_rise_q;
    logic strobe_q;
    logic lock_q;
    logic lock_d;
    logic not_ready_seen;
    logic sel_not_ready;
    logic sel_strobe;
    logic sel_locked;
    logic sel_receive;
    logic sel_burst;
    logic sel_ownership;
    logic hit_not_ready;
    logic hit_strobe;
    logic hit_locked;
    logic hit_receive;
    logic hit_burst;
    logic hit_ownership;
    logic hit_any;

    ////////////////////////////////////////////////////////////////////////////////
    // bus-facing drive

    // raise early so the queue never overruns what the bus can track
    assign not_ready_d = pending_count_in >= NOT_READY_LEVEL;

    // any lock cause holds the bus lock signal
    assign lock_d = lock_uncacheable_in || lock_split_line_in || lock_page_walk_in;

    // own assertion counts as seen, so a request never slips past our own hold-off
    assign not_ready_seen = bus_not_ready_in || not_ready_q;

    // registered drive of not-ready, strobe and lock
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            not_ready_q <= 1'b0;
            not_ready_rise_q <= 1'b0;
            strobe_q <= 1'b0;
            lock_q <= 1'b0;
        end else begin
            not_ready_q <= not_ready_d;
            not_ready_rise_q <= not_ready_d && !not_ready_q;
            strobe_q <= data_drive_in;
            lock_q <= lock_d;
        end
    end

    assign bus_not_ready_out = not_ready_q;
    assign data_valid_strobe_out = strobe_q;
    assign bus_lock_out = lock_q;

    ////////////////////////////////////////////////////////////////////////////////
    // request gate

    bpe_issue_gate u_gate (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .req_valid_in(req_valid_in),
        .req_kind_in(req_kind_in),
        .req_cacheable_in(req_cacheable_in),
        .not_ready_seen_in(not_ready_seen),
        .req_taken_out(req_taken_out),
        .link(link.gate)
    );

    assign bus_req_out = link.issue;

    ////////////////////////////////////////////////////////////////////////////////
    // event selection

    // one code per event; unknown codes never count
    assign sel_not_ready = event_select_in == EVT_NOT_READY_DRIVEN;
    assign sel_strobe = event_select_in == EVT_DATA_STROBE_CYCLES;
    assign sel_locked = event_select_in == EVT_LOCKED_CYCLES;
    assign sel_receive = event_select_in == EVT_RECEIVE_CYCLES;
    assign sel_burst = event_select_in == EVT_BURST_READS;
    assign sel_ownership = event_select_in == EVT_OWNERSHIP_READS;

    ////////////////////////////////////////////////////////////////////////////////
    // qualification
    // bus-level events look at our own drive and the shared bus, so one physical interface
    // gives one count however many threads run behind it

    // one count per rising edge of our own hold-off
    assign hit_not_ready = not_ready_rise_q;

    // bus strobe, or our own strobe, so our write data cycles always count
    assign hit_strobe = data_valid_strobe_in || strobe_q;

    // any agent's lock, ours included
    assign hit_locked = bus_lock_in || lock_q;

    // data on the bus from someone else and addressed to us
    assign hit_receive = data_valid_strobe_in && receive_for_us_in && !strobe_q;

    // transaction events count on the issue pulse only
    assign hit_burst = link.issue &&
                       bpe_is_burst_read(link.issue_kind, link.issue_cacheable);

    // ownership reads are kept out of the burst count by the kind decode
    assign hit_ownership = link.issue && bpe_is_ownership_read(link.issue_kind);

    // at most one selected hit, so one increment per clock
    assign hit_any = (sel_not_ready && hit_not_ready) ||
                     (sel_strobe && hit_strobe) ||
                     (sel_locked && hit_locked) ||
                     (sel_receive && hit_receive) ||
                     (sel_burst && hit_burst) ||
                     (sel_ownership && hit_ownership);

    assign link.inc = count_enable_in && hit_any;

    ////////////////////////////////////////////////////////////////////////////////
    // counter

    bpe_counter u_counter (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .clear_in(count_clear_in),
        .link(link.counter),
        .count_out(count_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    a_not_ready_level: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        bus_not_ready_out == ($past(pending_count_in) >= NOT_READY_LEVEL))
        else $error("bus_not_ready does not follow pending level");

    a_no_issue_held: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (bus_not_ready_in || bus_not_ready_out) |=> !bus_req_out)
        else $error("bus request issued during not-ready");

    a_strobe_drive: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        data_drive_in |=> data_valid_strobe_out)
        else $error("data driven without strobe");

    a_lock_causes: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        $rose(bus_lock_out) |-> $past(lock_uncacheable_in || lock_split_line_in ||
        lock_page_walk_in))
        else $error("lock raised without a cause");

    a_not_ready_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sel_not_ready && count_enable_in && !count_clear_in && $rose(bus_not_ready_out))
        |=> count_out == $past(count_out) + COUNT_STEP)
        else $error("not-ready assertion not counted");

    a_not_ready_once: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sel_not_ready && !count_clear_in && bus_not_ready_out && $past(bus_not_ready_out))
        |=> count_out == $past(count_out))
        else $error("held not-ready counted twice");

    a_strobe_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sel_strobe && count_enable_in && !count_clear_in && data_valid_strobe_in)
        |=> count_out == $past(count_out) + COUNT_STEP)
        else $error("strobe cycle not counted");

    a_own_write_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sel_strobe && count_enable_in && !count_clear_in && data_valid_strobe_out)
        |=> count_out == $past(count_out) + COUNT_STEP)
        else $error("own write cycle not counted");

    a_lock_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sel_locked && count_enable_in && !count_clear_in && bus_lock_in)
        |=> count_out == $past(count_out) + COUNT_STEP)
        else $error("locked cycle not counted");

    a_receive_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sel_receive && count_enable_in && !count_clear_in && data_valid_strobe_in &&
        receive_for_us_in && !data_valid_strobe_out)
        |=> count_out == $past(count_out) + COUNT_STEP)
        else $error("receive cycle not counted");

    a_burst_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sel_burst && count_enable_in && !count_clear_in && bus_req_out &&
        bpe_is_burst_read(link.issue_kind, link.issue_cacheable))
        |=> count_out == $past(count_out) + COUNT_STEP)
        else $error("burst read not counted");

    a_burst_no_own: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sel_burst && !count_clear_in && bpe_is_ownership_read(link.issue_kind))
        |=> count_out == $past(count_out))
        else $error("ownership read counted as burst read");

    a_store_own_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sel_ownership && count_enable_in && !count_clear_in && bus_req_out &&
        link.issue_kind == KIND_OWN_STORE_MISS)
        |=> count_out == $past(count_out) + COUNT_STEP)
        else $error("store ownership read not counted");

    a_lock_own_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sel_ownership && count_enable_in && !count_clear_in && bus_req_out &&
        link.issue_kind == KIND_OWN_LOCKED)
        |=> count_out == $past(count_out) + COUNT_STEP)
        else $error("locked ownership read not counted");

    a_no_idle_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (!count_enable_in && !count_clear_in) |=> count_out == $past(count_out))
        else $error("count moved while disabled");

    a_bus_per_iface: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sel_locked && count_enable_in && !count_clear_in && !bus_lock_in && !bus_lock_out)
        |=> count_out == $past(count_out))
        else $error("lock count moved without bus lock");

    // cycle outputs track their causes one edge later, except on the edge after reset
    a_strobe_follows: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !$past(rst_in) |-> data_valid_strobe_out == $past(data_drive_in))
        else $error("strobe does not follow data drive");

    a_lock_follows: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !$past(rst_in) |-> bus_lock_out == $past(lock_uncacheable_in ||
        lock_split_line_in || lock_page_walk_in))
        else $error("lock does not follow its causes");

    // only the rising edge of our own hold-off reaches the not-ready count
    a_rise_pulse: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        hit_not_ready |-> bus_not_ready_out && !$past(bus_not_ready_out))
        else $error("not-ready hit without a rising edge");

    a_not_ready_own: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sel_not_ready && !count_clear_in && !$rose(bus_not_ready_out))
        |=> count_out == $past(count_out))
        else $error("not-ready count moved without own rise");

    a_receive_no_own: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sel_receive && !count_clear_in && data_valid_strobe_out)
        |=> count_out == $past(count_out))
        else $error("own data counted as received");

    // codes outside the six events leave nothing to count; clear always zeroes
    a_unknown_code: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (!sel_not_ready && !sel_strobe && !sel_locked && !sel_receive && !sel_burst &&
        !sel_ownership && !count_clear_in)
        |=> count_out == $past(count_out))
        else $error("unknown event code counted");

    a_clear_wins: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        count_clear_in |=> count_out == COUNT_RESET)
        else $error("clear did not zero the count");

    // transaction events move only on the issue pulse, never while a request waits
    a_burst_issue: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sel_burst && !count_clear_in && !bus_req_out)
        |=> count_out == $past(count_out))
        else $error("burst count moved without an issue");

    a_own_issue: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sel_ownership && !count_clear_in && !bus_req_out)
        |=> count_out == $past(count_out))
        else $error("ownership count moved without an issue");

endmodule

// file: bpe_pkg.sv
package bpe_pkg;

    // event codes for the bus activity counters
    localparam logic [7:0] EVT_NOT_READY_DRIVEN = 8'h61;
    localparam logic [7:0] EVT_DATA_STROBE_CYCLES = 8'h62;
    localparam logic [7:0] EVT_LOCKED_CYCLES = 8'h63;
    localparam logic [7:0] EVT_RECEIVE_CYCLES = 8'h64;
    localparam logic [7:0] EVT_BURST_READS = 8'h65;
    localparam logic [7:0] EVT_OWNERSHIP_READS = 8'h66;

    // widths
    localparam int CNT_W = 40;
    localparam int PEND_W = 5;
    localparam int KIND_W = 3;

    // pending-queue limit and the margin that raises bus_not_ready early
    localparam logic [PEND_W-1:0] PENDING_MAX = 5'h10;
    localparam logic [PEND_W-1:0] PENDING_MARGIN = 5'h02;
    localparam logic [PEND_W-1:0] NOT_READY_LEVEL = PENDING_MAX - PENDING_MARGIN;

    // reset value and increment step
    localparam logic [CNT_W-1:0] COUNT_RESET = 40'h00_0000_0000;
    localparam logic [CNT_W-1:0] COUNT_STEP = 40'h00_0000_0001;

    // origin of a bus request coming from the core
    typedef enum logic [KIND_W-1:0] {
        KIND_OTHER = 3'h0,
        KIND_L1D_MISS = 3'h1,
        KIND_L1D_PREFETCH = 3'h2,
        KIND_L2_PREFETCH = 3'h3,
        KIND_L2_STREAMER = 3'h4,
        KIND_FETCH_MISS = 3'h5,
        KIND_OWN_STORE_MISS = 3'h6,
        KIND_OWN_LOCKED = 3'h7
    } bpe_kind_e;

    // burst read: data-cache misses and prefetches, cacheable fetch misses
    function automatic logic bpe_is_burst_read(input bpe_kind_e kind, input logic cacheable);
        bpe_is_burst_read = (kind == KIND_L1D_MISS) || (kind == KIND_L1D_PREFETCH) ||
                            (kind == KIND_L2_PREFETCH) || (kind == KIND_L2_STREAMER) ||
                            ((kind == KIND_FETCH_MISS) && cacheable);
    endfunction

    // read_for_ownership: store misses in both caches, or locked operations
    function automatic logic bpe_is_ownership_read(input bpe_kind_e kind);
        bpe_is_ownership_read = (kind == KIND_OWN_STORE_MISS) || (kind == KIND_OWN_LOCKED);
    endfunction

endpackage

// file: bpe_link_if.sv
`timescale 1ns/1ps
interface bpe_link_if;
    import bpe_pkg::*;

    logic issue;
    bpe_kind_e issue_kind;
    logic issue_cacheable;
    logic inc;

    // request gate reports each transaction it puts on the bus
    modport gate (output issue, output issue_kind, output issue_cacheable);
    // qualification consumes issues and produces one increment
    modport qual (input issue, input issue_kind, input issue_cacheable, output inc);
    // counter takes the increment
    modport counter (input inc);
endinterface

// file: bpe_issue_gate.sv
`timescale 1ns/1ps
module bpe_issue_gate
    import bpe_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic req_valid_in,
    input wire logic [KIND_W-1:0] req_kind_in,
    input wire logic req_cacheable_in,
    input wire logic not_ready_seen_in,
    output logic req_taken_out,
    bpe_link_if.gate link
);

    logic issue_q;
    logic issue_d;
    bpe_kind_e kind_q;
    logic cacheable_q;

    // hold new requests while anyone holds off the bus; spacing of two cycles
    assign issue_d = req_valid_in && !not_ready_seen_in && !issue_q;

    // issue pulse and the latched request attributes
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            issue_q <= 1'b0;
            kind_q <= KIND_OTHER;
            cacheable_q <= 1'b0;
        end else begin
            issue_q <= issue_d;
            if (issue_d) begin
                kind_q <= bpe_kind_e'(req_kind_in);
                cacheable_q <= req_cacheable_in;
            end
        end
    end

    assign req_taken_out = issue_q;
    assign link.issue = issue_q;
    assign link.issue_kind = kind_q;
    assign link.issue_cacheable = cacheable_q;

    a_gate_blocked: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        issue_q |-> !$past(not_ready_seen_in) && $past(req_valid_in))
        else $error("request issued while bus held off");

endmodule

// file: bpe_counter.sv
`timescale 1ns/1ps
module bpe_counter
    import bpe_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic clear_in,
    bpe_link_if.counter link,
    output logic [CNT_W-1:0] count_out
);

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;

    // clear beats increment; wraps silently, and nothing flags or handles overflow
    assign count_d = clear_in ? COUNT_RESET : (link.inc ? count_q + COUNT_STEP : count_q);

    // running total
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_q <= COUNT_RESET;
        end else begin
            count_q <= count_d;
        end
    end

    assign count_out = count_q;

    a_step_one: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !$past(clear_in) |-> (count_q == $past(count_q)) ||
        (count_q == $past(count_q) + COUNT_STEP))
        else $error("counter moved by more than one");

endmodule

// file: bpe_bus_model.sv
`timescale 1ns/1ps
// other agents on the shared bus; wire levels are the or of every agent
module bpe_bus_model
    import bpe_pkg::*;
#(
    parameter logic [PEND_W-1:0] OTHER_LEVEL = 5'h0E
)
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic own_not_ready_in,
    input wire logic own_strobe_in,
    input wire logic own_lock_in,
    input wire logic oth_drive_in,
    input wire logic oth_lock_in,
    input wire logic [PEND_W-1:0] oth_pending_in,
    output logic bus_not_ready_out,
    output logic data_valid_strobe_out,
    output logic bus_lock_out
);
    logic oth_not_ready_q;
    logic oth_not_ready_d;

    ////////////////////////////////////////////////////////////////////////
    // hold-off from the other agent when its queue nears the limit
    assign oth_not_ready_d = (oth_pending_in >= OTHER_LEVEL);
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            oth_not_ready_q <= 1'b0;
        end else begin
            oth_not_ready_q <= oth_not_ready_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // resolved wire levels; strobe follows the other agent's data drive
    assign bus_not_ready_out = own_not_ready_in | oth_not_ready_q;
    assign data_valid_strobe_out = own_strobe_in | oth_drive_in;
    assign bus_lock_out = own_lock_in | oth_lock_in;
endmodule

// file: bpe_top_test.sv
`timescale 1ns/1ps
module bpe_top_test;
    import bpe_pkg::*;

    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] sel = 8'h00;
    logic en = 1'b0;
    logic clr = 1'b0;
    logic [PEND_W-1:0] pend = 5'h00;
    logic [PEND_W-1:0] oth_pend = 5'h00;
    logic drive = 1'b0;
    logic rx = 1'b0;
    logic [2:0] lk = 3'h0;
    logic oth_drive = 1'b0;
    logic oth_lock = 1'b0;
    logic rv = 1'b0;
    logic rc = 1'b0;
    logic [KIND_W-1:0] rk = 3'h0;
    logic not_ready_w, strobe_w, lock_w, not_ready_o, strobe_o, lock_o, breq, taken;
    logic [CNT_W-1:0] cnt;
    int num_errors = 0;
    int check_count = 0;

    bpe_top u_bpe_top (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .event_select_in(sel),
        .count_enable_in(en), .count_clear_in(clr), .pending_count_in(pend),
        .bus_not_ready_in(not_ready_w), .data_drive_in(drive), .data_valid_strobe_in(strobe_w),
        .receive_for_us_in(rx), .lock_uncacheable_in(lk[2]), .lock_split_line_in(lk[1]),
        .lock_page_walk_in(lk[0]), .bus_lock_in(lock_w), .req_valid_in(rv),
        .req_kind_in(rk), .req_cacheable_in(rc), .bus_not_ready_out(not_ready_o),
        .data_valid_strobe_out(strobe_o), .bus_lock_out(lock_o), .bus_req_out(breq),
        .req_taken_out(taken), .count_out(cnt));

    bpe_bus_model u_bpe_bus_model (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .own_not_ready_in(not_ready_o), .own_strobe_in(strobe_o), .own_lock_in(lock_o),
        .oth_drive_in(oth_drive), .oth_lock_in(oth_lock), .oth_pending_in(oth_pend),
        .bus_not_ready_out(not_ready_w), .data_valid_strobe_out(strobe_w),
        .bus_lock_out(lock_w));

    ////////////////////////////////////////////////////////////////////////
    // clock, shared helpers and comparisons
    initial begin
        forever #10 sys_clk_in = ~sys_clk_in;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    // clear wins over increment, so events in the clear cycle are lost on purpose
    task automatic arm(input logic [7:0] code);
        sel = code;
        en = 1'b1;
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
    endtask

    task automatic chk_cnt(input logic [CNT_W-1:0] exp, input string what);
        check_count++;
        if (cnt !== exp) begin
            num_errors++;
            $display("BAD %0t %s count %0d expected %0d", $time, what, cnt, exp);
        end
    endtask

    task automatic chk_bit(input logic act, input logic exp, input string what);
        check_count++;
        if (act !== exp) begin
            num_errors++;
            $display("BAD %0t %s is %b expected %b", $time, what, act, exp);
        end
    endtask

    // request held through the edge that sees the taken pulse, then one idle edge
    task automatic issue(input logic [KIND_W-1:0] kind, input logic cach);
        int w;
        w = 0;
        rk = kind;
        rc = cach;
        rv = 1'b1;
        while (taken !== 1'b1 && w < 50) begin
            tick(1);
            w++;
        end
        chk_bit(breq, 1'b1, "bus request pulse");
        chk_bit(taken, 1'b1, "taken pulse");
        tick(1);
        rv = 1'b0;
        chk_bit(breq, 1'b0, "request pulse lasts one cycle");
        tick(1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic test_not_ready();
        arm(EVT_NOT_READY_DRIVEN);
        pend = 5'h0D;
        tick(3);
        chk_bit(not_ready_o, 1'b0, "not ready below level");
        pend = 5'h0E;
        tick(1);
        chk_bit(not_ready_o, 1'b1, "not ready at level");
        tick(4);
        pend = 5'h00;
        tick(2);
        chk_cnt(40'h00_0000_0001, "one long assertion");
        pend = 5'h10;
        tick(2);
        pend = 5'h00;
        tick(3);
        chk_cnt(40'h00_0000_0002, "second assertion");
    endtask

    task automatic test_strobe();
        arm(EVT_DATA_STROBE_CYCLES);
        drive = 1'b1;
        tick(1);
        chk_bit(strobe_o, 1'b1, "own strobe while writing");
        tick(2);
        drive = 1'b0;
        tick(1);
        oth_drive = 1'b1;
        tick(2);
        oth_drive = 1'b0;
        tick(3);
        chk_cnt(40'h00_0000_0005, "strobe cycles own and other");
    endtask

    task automatic test_lock();
        arm(EVT_LOCKED_CYCLES);
        for (int i = 0; i < 3; i++) begin
            lk = 3'h4 >> i;
            tick(1);
            chk_bit(lock_o, 1'b1, "lock for each cause");
            lk = 3'h0;
            tick(2);
        end
        oth_lock = 1'b1;
        tick(2);
        oth_lock = 1'b0;
        tick(2);
        chk_cnt(40'h00_0000_0005, "locked cycles");
    endtask

    task automatic test_receive();
        arm(EVT_RECEIVE_CYCLES);
        rx = 1'b1;
        oth_drive = 1'b1;
        tick(4);
        oth_drive = 1'b0;
        drive = 1'b1;
        tick(1);
        drive = 1'b0;
        tick(3);
        rx = 1'b0;
        chk_cnt(40'h00_0000_0004, "receive cycles, own data excluded");
    endtask

    // every kind, cacheable and not; expectations from the event definitions
    task automatic test_transactions();
        logic [CNT_W-1:0] exp;
        logic hit;
        for (int e = 0; e < 2; e++) begin
            arm(e == 0 ? EVT_BURST_READS : EVT_OWNERSHIP_READS);
            exp = COUNT_RESET;
            for (int k = 0; k < 8; k++) begin
                for (int c = 0; c < 2; c++) begin
                    issue(k[KIND_W-1:0], c[0]);
                    if (e == 0) begin
                        hit = (k >= 1 && k <= 4) || (k == 5 && c == 1);
                    end else begin
                        hit = (k == 6) || (k == 7);
                    end
                    exp = exp + {39'h0, hit};
                    chk_cnt(exp, "transaction count");
                end
            end
        end
    endtask

    task automatic test_hold_off();
        arm(EVT_BURST_READS);
        oth_pend = 5'h10;
        tick(2);
        rk = 3'h1;
        rc = 1'b0;
        rv = 1'b1;
        repeat (6) begin
            tick(1);
            chk_bit(breq, 1'b0, "no issue while held off");
        end
        oth_pend = 5'h00;
        issue(3'h1, 1'b0);
        chk_cnt(40'h00_0000_0001, "issue after release");
    endtask

    task automatic test_refused();
        arm(8'h67);
        drive = 1'b1;
        tick(3);
        sel = EVT_DATA_STROBE_CYCLES;
        en = 1'b0;
        tick(3);
        en = 1'b1;
        clr = 1'b1;
        tick(2);
        clr = 1'b0;
        drive = 1'b0;
        chk_cnt(COUNT_RESET, "unknown code, disabled, clear");
    endtask

    // reset in mid-run drops every output at once and counting restarts from zero
    task automatic test_reset();
        arm(EVT_DATA_STROBE_CYCLES);
        pend = 5'h10;
        drive = 1'b1;
        lk = 3'h4;
        tick(2);
        chk_bit(not_ready_o, 1'b1, "not ready before reset");
        chk_cnt(40'h00_0000_0001, "strobe cycle before reset");
        rst_in = 1'b1;
        pend = 5'h00;
        drive = 1'b0;
        lk = 3'h0;
        #2;
        chk_bit(not_ready_o, 1'b0, "not ready in reset");
        chk_bit(strobe_o, 1'b0, "strobe in reset");
        chk_bit(lock_o, 1'b0, "lock in reset");
        chk_cnt(COUNT_RESET, "count in reset");
        tick(2);
        rst_in = 1'b0;
        tick(1);
        chk_bit(strobe_o, 1'b0, "strobe after reset");
        chk_cnt(COUNT_RESET, "count after mid-run reset");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // verdict, watchdog and main sequence
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #100000;
        num_errors++;
        $display("BAD %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        repeat (8) @(posedge sys_clk_in);
        #1;
        rst_in = 1'b0;
        tick(1);
        chk_cnt(COUNT_RESET, "count after reset");
        test_not_ready();
        test_strobe();
        test_lock();
        test_receive();
        test_transactions();
        test_hold_off();
        test_refused();
        test_reset();
        complete_run();
    end
endmodule
